// ### verilog/hisf_pkg.sv
// hisf_pkg: shared constants and types of the host interface selector
// assumes a 25 MHz core clock; the buffer level is reported by the print engine
package hisf_pkg;
  // core clock rate
  localparam int unsigned CLK_HZ = 25000000;
  // serial flow thresholds in bytes of free space
  localparam logic [15:0] FREE_STOP = 16'h0C00;
  localparam logic [15:0] FREE_RESUME = 16'h1400;
  // free space under which the trickle accept starts
  localparam logic [15:0] FREE_TRICKLE = 16'h0200;
  // trickle: one byte per this many seconds (a few bytes per minute)
  localparam int unsigned TRICKLE_S = 15;
  // idle return timeout in seconds
  localparam int unsigned IDLE_S = 10;
  // nonvolatile locations of the packet mode settings
  localparam logic [7:0] NV_PAR_MODE = 8'h0A;
  localparam logic [7:0] NV_USB_MODE = 8'h0C;
  // settings register offsets on the plain port
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_FREE = 4'h2;
  // field positions in the mode register
  localparam int unsigned MODE_PAR_LSB = 0;
  localparam int unsigned MODE_USB_LSB = 2;
  // flow codes
  localparam logic [7:0] CODE_XON = 8'h11;
  localparam logic [7:0] CODE_XOFF = 8'h13;
  // packet transport sync byte (first byte of the magic string)
  localparam logic [7:0] SYNC_BYTE = 8'h00;
  localparam logic [7:0] SYNC_LEN = 8'h08;
  // packet mode settings
  typedef enum logic [1:0] {HISF_PKT_OFF = 2'h0, HISF_PKT_ON = 2'h1,
                            HISF_PKT_AUTO = 2'h2} hisf_pkt_t;
  // active port
  typedef enum logic [1:0] {HISF_NONE, HISF_PAR, HISF_SER, HISF_USB} hisf_port_t;
endpackage

// ### verilog/hisf_sync.sv
// hisf_sync: two-flop synchroniser for a bus of asynchronous levels
// assumes the inputs come from pins outside the core clock domain
`timescale 1ns/1ps
module hisf_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // first stage is read only by the second
  logic [W-1:0] meta;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// ### verilog/hisf_top.sv
// hisf_top: host port selection, serial flow control and packet filter
// assumes pins are asynchronous, buffer level comes from the engine
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - stop below 3072 free, resume above 5120
// - trickle accept when nearly full
// - full buffer: busy unless idle, accept nothing
// - idle scan, first active port wins
// - standby timeout returns to idle
// - keep selection while data or busy
// - unselected parallel port held busy
// - unselected serial ready at MARK
// - idle: parallel ready, serial SPACE
// - ignore init on unselected port
// - per-port packet mode, locations 0Ah/0Ch
// - On: discard until sync, then packet
// - Off: stream, discard sync string
// - Auto: stream until sync, then packet
// - packet channels blocked independently
// - USB full speed, NRZI coded
// - stream error: error low, busy high unless idle, stop
// - init pulse clears buffers
module hisf_top #(
  parameter int unsigned IDLE_SECONDS = hisf_pkg::IDLE_S,
  parameter int unsigned IDLE_CYCLES = IDLE_SECONDS * hisf_pkg::CLK_HZ,
  parameter int unsigned TRICKLE_CYCLES = hisf_pkg::TRICKLE_S * hisf_pkg::CLK_HZ,
  parameter int unsigned NCHAN = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // settings port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // parallel pins
  input wire logic par_strobe_n_i,
  input wire logic par_init_n_i,
  input wire logic [7:0] par_data_i,
  output logic par_busy_o,
  output logic par_error_n_o,
  // serial pins: clock is sampled as a level
  input wire logic ser_clk_i,
  input wire logic ser_rxd_i,
  output logic ser_txd_o,
  output logic ser_dtr_o,
  // usb decoded byte from the line receiver
  input wire logic usb_valid_i,
  input wire logic [7:0] usb_data_i,
  input wire logic [1:0] usb_chan_i,
  // engine side
  input wire logic [15:0] free_i,
  input wire logic error_i,
  input wire logic [NCHAN-1:0] chan_block_i,
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  output logic byte_pkt_o,
  output logic [1:0] byte_chan_o,
  output logic [1:0] sel_port_o,
  output logic init_o
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [11:0] pin_s;
  hisf_sync #(.W(12)) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i({par_strobe_n_i, par_init_n_i, ser_clk_i, ser_rxd_i, par_data_i}),
    .q_o(pin_s)
  );
  logic strb_s, init_s, sclk_s, rxd_s;
  logic [7:0] pdat_s;
  assign {strb_s, init_s, sclk_s, rxd_s, pdat_s} = pin_s;
  // previous samples for edge detection
  logic strb_d, init_d, sclk_d;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // the synchroniser leaves reset low: start low too, so no false fall
      strb_d <= 1'b0;
      init_d <= 1'b0;
      sclk_d <= 1'b0;
    end else begin
      strb_d <= strb_s;
      init_d <= init_s;
      sclk_d <= sclk_s;
    end
  end
  logic par_stb, init_fall, sclk_rise, sclk_fall;
  assign par_stb = strb_d & ~strb_s;
  assign init_fall = init_d & ~init_s;
  assign sclk_rise = ~sclk_d & sclk_s;
  assign sclk_fall = sclk_d & ~sclk_s;

  ////////////////////////////////////////////////////////////////////////////
  // settings registers; the usb line interface itself is a full speed NRZI
  // transceiver outside this block, delivering decoded bytes
  hisf_pkg::hisf_pkt_t mode_par, mode_usb;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_par <= hisf_pkg::HISF_PKT_AUTO;
      mode_usb <= hisf_pkg::HISF_PKT_AUTO;
    end else if (wr_i && addr_i == hisf_pkg::REG_MODE) begin
      // loaded by firmware from nonvolatile locations 0Ah and 0Ch
      mode_par <= hisf_pkg::hisf_pkt_t'(wdata_i[hisf_pkg::MODE_PAR_LSB +: 2]);
      mode_usb <= hisf_pkg::hisf_pkt_t'(wdata_i[hisf_pkg::MODE_USB_LSB +: 2]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial receiver: start bit, 8 data, stop, sampled on clock rise
  logic [3:0] rx_cnt;
  logic [7:0] rx_sh;
  logic rx_done;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_cnt <= 4'h0;
      rx_sh <= 8'h00;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (sclk_rise) begin
        if (rx_cnt == 4'h0) begin
          // waiting for start bit (low)
          if (!rxd_s) rx_cnt <= 4'h1;
        end else if (rx_cnt == 4'h9) begin
          // stop bit ends the word
          rx_cnt <= 4'h0;
          rx_done <= 1'b1;
        end else begin
          rx_sh <= {rxd_s, rx_sh[7:1]};
          rx_cnt <= rx_cnt + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port selection state machine
  typedef enum logic [1:0] {S_IDLE, S_ACTIVE} hisf_sel_t;
  hisf_sel_t state;
  hisf_pkg::hisf_port_t port;
  logic [$clog2(IDLE_CYCLES+1)-1:0] idle_cnt;
  logic sel_busy;
  logic any_par, any_ser, any_usb;
  assign any_par = par_stb;
  assign any_ser = rx_done;
  assign any_usb = usb_valid_i;
  // port that owns this cycle: in idle the winner of the scan
  hisf_pkg::hisf_port_t cur_port;
  always_comb begin
    cur_port = port;
    if (state == S_IDLE) begin
      if (any_par) cur_port = hisf_pkg::HISF_PAR;
      else if (any_ser) cur_port = hisf_pkg::HISF_SER;
      else if (any_usb) cur_port = hisf_pkg::HISF_USB;
      else cur_port = hisf_pkg::HISF_NONE;
    end
  end
  logic port_act;
  always_comb begin
    unique case (cur_port)
      hisf_pkg::HISF_PAR: port_act = any_par;
      hisf_pkg::HISF_SER: port_act = any_ser;
      hisf_pkg::HISF_USB: port_act = any_usb;
      default: port_act = 1'b0;
    endcase
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= S_IDLE;
      port <= hisf_pkg::HISF_NONE;
      idle_cnt <= '0;
    end else begin
      unique case (state)
        S_IDLE: begin
          // first port with data is selected, its first byte kept
          idle_cnt <= '0;
          if (cur_port != hisf_pkg::HISF_NONE) begin
            state <= S_ACTIVE;
            port <= cur_port;
          end
        end
        S_ACTIVE: begin
          if (port_act || sel_busy) begin
            // data or busy keeps the selection
            idle_cnt <= '0;
          end else if (idle_cnt >= IDLE_CYCLES[$bits(idle_cnt)-1:0] - 1'b1) begin
            // standby for the configured seconds returns to idle
            state <= S_IDLE;
            port <= hisf_pkg::HISF_NONE;
            idle_cnt <= '0;
          end else begin
            idle_cnt <= idle_cnt + 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer flow control
  logic full, trickle_zone, flow_stop;
  assign full = free_i == 16'h0000;
  assign trickle_zone = free_i < hisf_pkg::FREE_TRICKLE;
  // serial stop/resume with hysteresis
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flow_stop <= 1'b0;
    end else if (free_i < hisf_pkg::FREE_STOP) begin
      flow_stop <= 1'b1;
    end else if (free_i > hisf_pkg::FREE_RESUME) begin
      flow_stop <= 1'b0;
    end
    // between thresholds the state is held
  end
  // trickle timer grants one byte now and then while nearly full
  logic [$clog2(TRICKLE_CYCLES+1)-1:0] tr_cnt;
  logic tr_grant;
  logic take;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tr_cnt <= '0;
      tr_grant <= 1'b0;
    end else if (!trickle_zone || full) begin
      tr_cnt <= '0;
      tr_grant <= 1'b0;
    end else if (take) begin
      tr_grant <= 1'b0;
    end else if (tr_cnt >= TRICKLE_CYCLES[$bits(tr_cnt)-1:0] - 1'b1) begin
      tr_cnt <= '0;
      tr_grant <= 1'b1;
    end else begin
      tr_cnt <= tr_cnt + 1'b1;
    end
  end
  // packet mode holds through errors
  logic pkt_par, pkt_usb, in_pkt, err_stop;
  assign in_pkt = (port == hisf_pkg::HISF_PAR && pkt_par) ||
                  (port == hisf_pkg::HISF_USB && pkt_usb);
  assign err_stop = error_i && !in_pkt;
  // accept: room and no error; near full only on a trickle grant
  logic accept;
  assign accept = !full && !err_stop && (!trickle_zone || tr_grant);
  assign sel_busy = !accept;

  ////////////////////////////////////////////////////////////////////////////
  // packet transport filters, one per packet-capable port
  logic [7:0] cur_byte;
  logic cur_valid;
  logic [1:0] cur_chan;
  always_comb begin
    cur_valid = port_act && accept;
    cur_byte = 8'h00;
    cur_chan = 2'h0;
    unique case (cur_port)
      hisf_pkg::HISF_PAR: cur_byte = pdat_s;
      hisf_pkg::HISF_SER: cur_byte = rx_sh;
      hisf_pkg::HISF_USB: begin
        cur_byte = usb_data_i;
        cur_chan = usb_chan_i;
      end
      default: cur_byte = 8'h00;
    endcase
  end
  assign take = cur_valid;
  // count consecutive sync bytes per port
  logic [7:0] sync_par, sync_usb;
  logic hit_par, hit_usb;
  assign hit_par = port == hisf_pkg::HISF_PAR && cur_valid &&
                   cur_byte == hisf_pkg::SYNC_BYTE &&
                   sync_par == hisf_pkg::SYNC_LEN - 8'h01;
  assign hit_usb = port == hisf_pkg::HISF_USB && cur_valid &&
                   cur_byte == hisf_pkg::SYNC_BYTE &&
                   sync_usb == hisf_pkg::SYNC_LEN - 8'h01;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_par <= 8'h00;
      sync_usb <= 8'h00;
      pkt_par <= 1'b0;
      pkt_usb <= 1'b0;
    end else if (state == S_IDLE || init_o) begin
      sync_par <= 8'h00;
      sync_usb <= 8'h00;
      pkt_par <= 1'b0;
      pkt_usb <= 1'b0;
    end else if (cur_valid) begin
      if (port == hisf_pkg::HISF_PAR) begin
        sync_par <= (cur_byte == hisf_pkg::SYNC_BYTE && !hit_par) ? sync_par + 8'h01 : 8'h00;
        // On and Auto enter packet mode on sync; Off never
        if (hit_par && mode_par != hisf_pkg::HISF_PKT_OFF) pkt_par <= 1'b1;
      end
      if (port == hisf_pkg::HISF_USB) begin
        sync_usb <= (cur_byte == hisf_pkg::SYNC_BYTE && !hit_usb) ? sync_usb + 8'h01 : 8'h00;
        if (hit_usb && mode_usb != hisf_pkg::HISF_PKT_OFF) pkt_usb <= 1'b1;
      end
    end
  end
  // forwarding decision
  hisf_pkg::hisf_pkt_t cur_mode;
  logic cur_pkt, fwd;
  always_comb begin
    cur_mode = hisf_pkg::HISF_PKT_OFF;
    if (cur_port == hisf_pkg::HISF_PAR) cur_mode = mode_par;
    if (cur_port == hisf_pkg::HISF_USB) cur_mode = mode_usb;
    cur_pkt = in_pkt;
    fwd = cur_valid;
    if (!cur_pkt && cur_mode == hisf_pkg::HISF_PKT_ON) fwd = 1'b0;
    // sync bytes are never passed as stream data
    if (!cur_pkt && cur_byte == hisf_pkg::SYNC_BYTE) fwd = 1'b0;
    // a blocked channel drops only its own traffic
    if (cur_pkt && chan_block_i[cur_chan]) fwd = 1'b0;
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      byte_valid_o <= 1'b0;
      byte_o <= 8'h00;
      byte_pkt_o <= 1'b0;
      byte_chan_o <= 2'h0;
    end else begin
      byte_valid_o <= fwd;
      byte_o <= cur_byte;
      byte_pkt_o <= cur_pkt;
      byte_chan_o <= cur_chan;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parallel status pins and init
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      par_busy_o <= 1'b0;
      par_error_n_o <= 1'b1;
      init_o <= 1'b0;
    end else begin
      if (state == S_IDLE) par_busy_o <= 1'b0;
      else if (port != hisf_pkg::HISF_PAR) par_busy_o <= 1'b1;
      else par_busy_o <= !accept;
      par_error_n_o <= !err_stop;
      // only the selected parallel port honours init
      init_o <= init_fall && state == S_ACTIVE && port == hisf_pkg::HISF_PAR;
    end
  end
  // serial terminal ready (1 = SPACE/on) and flow code transmitter
  logic flow_d;
  logic [3:0] tx_cnt;
  logic [9:0] tx_sh;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ser_dtr_o <= 1'b1;
      flow_d <= 1'b0;
      tx_cnt <= 4'h0;
      tx_sh <= 10'h3FF;
      ser_txd_o <= 1'b1;
    end else begin
      if (state == S_IDLE) ser_dtr_o <= 1'b1;
      else if (port != hisf_pkg::HISF_SER) ser_dtr_o <= 1'b0;
      else ser_dtr_o <= !flow_stop;
      if (flow_d != flow_stop && tx_cnt == 4'h0 && port == hisf_pkg::HISF_SER) begin
        // load stop/resume code with start and stop bits
        flow_d <= flow_stop;
        tx_sh <= {1'b1, flow_stop ? hisf_pkg::CODE_XOFF : hisf_pkg::CODE_XON, 1'b0};
        tx_cnt <= 4'hA;
      end else if (port != hisf_pkg::HISF_SER) begin
        flow_d <= flow_stop;
      end
      if (sclk_fall && tx_cnt != 4'h0) begin
        ser_txd_o <= tx_sh[0];
        tx_sh <= {1'b1, tx_sh[9:1]};
        tx_cnt <= tx_cnt - 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      unique case (addr_i)
        hisf_pkg::REG_MODE: rdata_o <= {12'h000, mode_usb, mode_par};
        hisf_pkg::REG_STATUS: rdata_o <= {9'h000, pkt_usb, pkt_par, flow_stop,
                                          state == S_ACTIVE, sel_busy, port};
        hisf_pkg::REG_FREE: rdata_o <= free_i;
        default: rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) sel_port_o <= 2'h0;
    else sel_port_o <= port;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_busy_when_full: assert property (@(posedge clk_i) disable iff (!resetn_i)
    full && state == S_ACTIVE && port == hisf_pkg::HISF_PAR |=> par_busy_o)
    else $error("parallel not busy while buffer full");
  a_no_take_full: assert property (@(posedge clk_i) disable iff (!resetn_i)
    full |=> !byte_valid_o)
    else $error("byte accepted with full buffer");
  a_flow_stop_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
    free_i < hisf_pkg::FREE_STOP |=> flow_stop)
    else $error("flow not stopped below low mark");
  a_flow_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    free_i >= hisf_pkg::FREE_STOP && free_i <= hisf_pkg::FREE_RESUME
    |=> flow_stop == $past(flow_stop))
    else $error("flow changed between thresholds");
  a_par_unsel_busy: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == S_ACTIVE && port != hisf_pkg::HISF_PAR |=> par_busy_o)
    else $error("unselected parallel not busy");
  a_ser_unsel_mark: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == S_ACTIVE && port != hisf_pkg::HISF_SER |=> !ser_dtr_o)
    else $error("unselected serial ready not at mark");
  a_idle_ready: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == S_IDLE |=> !par_busy_o && ser_dtr_o)
    else $error("idle outputs not ready");
  a_init_gated: assert property (@(posedge clk_i) disable iff (!resetn_i)
    init_fall && port != hisf_pkg::HISF_PAR |=> !init_o)
    else $error("init honoured on unselected port");
  a_sel_kept: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == S_ACTIVE && (port_act || sel_busy) |=> port == $past(port))
    else $error("selection lost while active");
  a_err_stops: assert property (@(posedge clk_i) disable iff (!resetn_i)
    err_stop |=> !par_error_n_o && !byte_valid_o)
    else $error("error did not stop reception");
endmodule

// ### bench/hisf_host.sv
// hisf_host: host computer model on the parallel, serial and usb ports
// assumes the core clock is shared; the serial clock is made here, 320 ns
`timescale 1ns/1ps
module hisf_host (
  // core clock
  input wire logic clk_i,
  // parallel pins
  output logic par_strobe_n_o,
  output logic par_init_n_o,
  output logic [7:0] par_data_o,
  // serial pins
  output logic ser_clk_o,
  output logic ser_rxd_o,
  input wire logic ser_txd_i,
  // usb decoded bytes
  output logic usb_valid_o,
  output logic [7:0] usb_data_o,
  output logic [1:0] usb_chan_o
);
  ////////////////////////////////////////////////////////////////////////////
  // idle levels: strobes high, serial clock stands still high
  initial begin
    par_strobe_n_o = 1'b1;
    par_init_n_o = 1'b1;
    par_data_o = 8'h00;
    ser_clk_o = 1'b1;
    ser_rxd_o = 1'b1;
    usb_valid_o = 1'b0;
    usb_data_o = 8'h00;
    usb_chan_o = 2'h0;
  end
  // parallel byte: data settles, strobe low, data held well past the strobe
  task automatic par_send(input logic [7:0] b);
    @(posedge clk_i) par_data_o <= b;
    repeat (4) @(posedge clk_i);
    par_strobe_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    par_strobe_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    par_data_o <= ~b; // stale data must not look like the last byte
  endtask
  // negative pulse on the init pin
  task automatic par_init();
    @(posedge clk_i) par_init_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    par_init_n_o <= 1'b1;
  endtask
  // one decoded usb byte, a single cycle
  task automatic usb_send(input logic [7:0] b, input logic [1:0] ch);
    @(posedge clk_i) usb_valid_o <= 1'b1;
    usb_data_o <= b;
    usb_chan_o <= ch;
    @(posedge clk_i) usb_valid_o <= 1'b0;
    usb_data_o <= ~b; // no longer valid, so show something else
  endtask
  // 24 serial clocks: optionally send a frame, and decode any frame on txd
  task automatic ser_run(input logic send, input logic [7:0] tx, output logic [7:0] got);
    logic [9:0] frame;
    logic [23:0] seen;
    int i;
    frame = {1'b1, tx, 1'b0};
    got = 8'hFF;
    for (i = 0; i < 24; i++) begin
      ser_clk_o = 1'b0;
      ser_rxd_o = (send && i < 10) ? frame[i] : 1'b1;
      #160;
      ser_clk_o = 1'b1;
      seen[i] = ser_txd_i;
      #160;
    end
    // earliest start bit wins: scan downwards, the last match is kept
    for (i = 15; i >= 0; i--) begin
      if (seen[i] === 1'b0) got = seen[i+1 +: 8];
    end
  endtask
endmodule

// ### bench/hisf_top_test.sv
// hisf_top_test: self-checking bench of the host interface selector
// assumes hisf_host drives the host pins; short idle and trickle counts
`timescale 1ns/1ps
`define CHECK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module hisf_top_test;
  // core and settings port
  logic clk, resetn, wr, rd;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [15:0] rdata, free, d;
  // host pins
  logic par_strobe_n, par_init_n, par_busy, par_error_n;
  logic [7:0] par_data, usb_data, byte_d, g;
  logic ser_clk, ser_rxd, ser_txd, ser_dtr, usb_valid;
  logic [1:0] usb_chan, byte_chan, sel_port;
  // engine side
  logic error, byte_valid, byte_pkt, init_pulse;
  logic [3:0] chan_block;
  // bench state
  int miscompares = 0, n_compared = 0, n_fwd = 0, n_init = 0, n0, m, k;
  logic [7:0] last_byte;
  logic last_pkt;
  logic [1:0] last_chan;
  hisf_top #(.IDLE_CYCLES(600), .TRICKLE_CYCLES(50)) dut (.clk_i(clk), .resetn_i(resetn),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .par_strobe_n_i(par_strobe_n), .par_init_n_i(par_init_n), .par_data_i(par_data),
    .par_busy_o(par_busy), .par_error_n_o(par_error_n), .ser_clk_i(ser_clk),
    .ser_rxd_i(ser_rxd), .ser_txd_o(ser_txd), .ser_dtr_o(ser_dtr), .usb_valid_i(usb_valid),
    .usb_data_i(usb_data), .usb_chan_i(usb_chan), .free_i(free), .error_i(error),
    .chan_block_i(chan_block), .byte_valid_o(byte_valid), .byte_o(byte_d),
    .byte_pkt_o(byte_pkt), .byte_chan_o(byte_chan), .sel_port_o(sel_port),
    .init_o(init_pulse));
  hisf_host host (.clk_i(clk), .par_strobe_n_o(par_strobe_n), .par_init_n_o(par_init_n),
    .par_data_o(par_data), .ser_clk_o(ser_clk), .ser_rxd_o(ser_rxd), .ser_txd_i(ser_txd),
    .usb_valid_o(usb_valid), .usb_data_o(usb_data), .usb_chan_o(usb_chan));
  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    test_done();
  end
  // monitor of forwarded bytes and init pulses
  // sampled mid-cycle, where the registered outputs have settled
  always @(negedge clk) begin
    if (byte_valid === 1'b1) begin
      n_fwd++;
      last_byte = byte_d;
      last_pkt = byte_pkt;
      last_chan = byte_chan;
    end
    if (init_pulse === 1'b1) n_init++;
  end
  ////////////////////////////////////////////////////////////////////////////
  // settings port accesses and helpers
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk) addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk) addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge clk) resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    settle(1);
  endtask
  task automatic test_done();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {resetn, wr, rd, error, addr, wdata, chan_block} = '0;
    free = 16'hFFFF;
    do_reset();
    // reset state: scanning, parallel ready, serial at SPACE
    reg_rd(hisf_pkg::REG_MODE, d);
    `CHECK(d, 16'h000A)
    `CHECK(sel_port, 2'h0)
    `CHECK(par_busy, 1'b0)
    `CHECK(ser_dtr, 1'b1)
    reg_rd(4'hF, d);
    `CHECK(d, 16'h0000)
    // parallel wins, serial goes to MARK, init honoured
    reg_wr(hisf_pkg::REG_MODE, 8'h00);
    host.par_send(8'h41);
    settle(10);
    `CHECK(sel_port, 2'h1)
    `CHECK(last_byte, 8'h41)
    `CHECK(ser_dtr, 1'b0)
    host.par_init();
    settle(10);
    `CHECK(n_init, 1)
    host.usb_send(8'h77, 2'h0);
    settle(400);
    `CHECK(sel_port, 2'h1)
    settle(300);
    `CHECK(sel_port, 2'h0)
    `CHECK(par_busy, 1'b0)
    `CHECK(ser_dtr, 1'b1)
    // serial wins; parallel held busy and its init ignored
    host.ser_run(1'b1, 8'h52, g);
    settle(10);
    `CHECK(sel_port, 2'h2)
    `CHECK(last_byte, 8'h52)
    `CHECK(par_busy, 1'b1)
    host.par_init();
    settle(10);
    `CHECK(n_init, 1)
    // flow thresholds and hysteresis, both boundaries
    free = 16'd3072;
    settle(10);
    `CHECK(ser_dtr, 1'b1)
    free = 16'd3071;
    settle(10);
    `CHECK(ser_dtr, 1'b0)
    host.ser_run(1'b1, 8'h53, g);
    `CHECK(g, hisf_pkg::CODE_XOFF)
    free = 16'd5120;
    settle(10);
    `CHECK(ser_dtr, 1'b0)
    free = 16'd5121;
    settle(10);
    `CHECK(ser_dtr, 1'b1)
    host.ser_run(1'b1, 8'h54, g);
    `CHECK(g, hisf_pkg::CODE_XON)
    free = 16'hFFFF;
    // usb packet modes off, on, auto; channel 1 blocked
    chan_block = 4'h2;
    for (m = 0; m < 3; m++) begin
      do_reset();
      reg_wr(hisf_pkg::REG_MODE, {4'h0, m[1:0], 2'h0});
      n0 = n_fwd;
      host.usb_send(8'h55, 2'h0);
      settle(10);
      `CHECK(n_fwd - n0, (m == 1) ? 0 : 1)
      n0 = n_fwd;
      for (k = 0; k < 8; k++) host.usb_send(hisf_pkg::SYNC_BYTE, 2'h2);
      host.usb_send(8'h56, 2'h2);
      settle(10);
      `CHECK(n_fwd - n0, 1)
      `CHECK(last_pkt, (m == 0) ? 1'b0 : 1'b1)
      `CHECK(last_chan, 2'h2)
      reg_rd(hisf_pkg::REG_STATUS, d);
      `CHECK(d, (m == 0) ? 16'h000B : 16'h004B)
      // channel 1 is blocked: only its own byte is dropped in packet mode
      n0 = n_fwd;
      host.usb_send(8'h58, 2'h1);
      host.usb_send(8'h59, 2'h2);
      settle(10);
      `CHECK(n_fwd - n0, (m == 0) ? 2 : 1)
      `CHECK(last_byte, 8'h59)
      // engine error: stream stops, packet traffic continues
      error = 1'b1;
      n0 = n_fwd;
      host.usb_send(8'h57, 2'h2);
      settle(10);
      `CHECK(n_fwd - n0, (m == 0) ? 0 : 1)
      if (m == 0) `CHECK({par_error_n, par_busy}, 2'b01)
      error = 1'b0;
    end
    // full buffer refuses, nearly full trickles
    do_reset();
    host.usb_send(8'h60, 2'h0);
    settle(10);
    free = 16'h0000;
    n0 = n_fwd;
    for (k = 0; k < 3; k++) host.usb_send(8'h61, 2'h0);
    settle(10);
    `CHECK(n_fwd - n0, 0)
    free = 16'd100;
    n0 = n_fwd;
    for (k = 0; k < 12; k++) begin
      host.usb_send(8'h62, 2'h0);
      settle(8);
    end
    `CHECK((n_fwd - n0) inside {[1:3]}, 1'b1)
    reg_rd(hisf_pkg::REG_FREE, d);
    `CHECK(d, 16'h0064)
    test_done();
  end
endmodule
